//--- logic/duty_cycle_pulse_timer.sv
`timescale 1ns/1ns
`default_nettype none
module duty_cycle_pulse_timer #(
  parameter int CNT_WIDTH = pulse_timer_pkg::CNT_WIDTH
) (
  input  wire logic                 clock_i,           // 125 MHz system clock
  input  wire logic                 sys_rst_i,         // async reset, high
  input  wire logic                 flag_input_line_i, // sensor output line
  input  wire logic                 start_i,           // pulse: begin measurement
  output logic [CNT_WIDTH-1:0]      high_phase_time_o, // latched high count
  output logic [CNT_WIDTH-1:0]      low_phase_time_o,  // latched low count
  output logic                      done_o,            // pulse: pair latched
  output logic                      busy_o,            // measurement running
  output logic                      error_o            // sticky msb overflow
);
  // synchroniser stages
  logic sync_a;
  logic sync_b;
  logic line_d;                           // delayed level for edge detect
  // prescaler and tick
  logic [7:0] prescale;
  logic       tick;
  // counter and sequencer
  logic [CNT_WIDTH-1:0]         count;
  pulse_timer_pkg::meas_state_e state;
  logic [CNT_WIDTH-1:0]         high_lat;
  logic [CNT_WIDTH-1:0]         low_lat;
  logic                         done_r;
  logic                         busy_r;
  logic                         err_r;
  // next values
  logic [7:0]                   next_prescale;
  logic                         next_tick;
  logic [CNT_WIDTH-1:0]         next_count;
  pulse_timer_pkg::meas_state_e next_state;
  logic [CNT_WIDTH-1:0]         next_high_lat;
  logic [CNT_WIDTH-1:0]         next_low_lat;
  logic                         next_done;
  logic                         next_busy;
  logic                         next_err;
  // edge pulses from the settled level
  logic edge_any;
  logic rise;
  logic fall;

  // two-stage synchroniser, first stage feeds only the second
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      // idle-high reset level: no false rise once the pulled-up line settles
      sync_a <= 1'b1;
      sync_b <= 1'b1;
      line_d <= 1'b1;
    end else begin
      sync_a <= flag_input_line_i;
      sync_b <= sync_a;
      line_d <= sync_b;
    end
  end

  // one pulse per transition, split by level
  assign edge_any = sync_b ^ line_d;
  assign rise     = edge_any & sync_b;
  assign fall     = edge_any & ~sync_b;

  // prescaler: reload n-1, tick when it reaches zero
  always_comb begin
    next_tick     = 1'b0;
    next_prescale = prescale - 8'h01;
    if (prescale == 8'h00) begin
      next_prescale = pulse_timer_pkg::PRESCALE_LOAD;
      next_tick     = 1'b1;
    end
  end

  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      prescale <= 8'h00;
      tick     <= 1'b0;
    end else begin
      prescale <= next_prescale;
      tick     <= next_tick;
    end
  end

  // measurement sequencer, counter and latches
  always_comb begin
    next_state    = state;
    next_count    = count;
    next_high_lat = high_lat;
    next_low_lat  = low_lat;
    next_done     = 1'b0;
    next_busy     = busy_r;
    next_err      = err_r;
    case (state)
      pulse_timer_pkg::ST_IDLE: begin
        if (start_i) begin
          next_count = CNT_WIDTH'(pulse_timer_pkg::CNT_RESET);
          next_err   = 1'b0;
          next_busy  = 1'b1;
          next_state = pulse_timer_pkg::ST_WAIT_LOW;
        end
      end
      pulse_timer_pkg::ST_WAIT_LOW: begin
        if (!sync_b) begin
          next_state = pulse_timer_pkg::ST_WAIT_HI;
        end
      end
      pulse_timer_pkg::ST_WAIT_HI: begin
        if (rise) begin
          next_count = CNT_WIDTH'(pulse_timer_pkg::CNT_RESET);
          next_state = pulse_timer_pkg::ST_HIGH;
        end
      end
      pulse_timer_pkg::ST_HIGH: begin
        if (fall) begin
          next_high_lat = count;
          next_count    = CNT_WIDTH'(pulse_timer_pkg::CNT_RESET);
          next_state    = pulse_timer_pkg::ST_LOW;
        end else if (tick && !count[CNT_WIDTH-1]) begin
          next_count = count + 1'b1;
        end
      end
      pulse_timer_pkg::ST_LOW: begin
        if (rise) begin
          next_low_lat = count;
          next_count   = CNT_WIDTH'(pulse_timer_pkg::CNT_RESET);
          next_done    = 1'b1;
          next_busy    = 1'b0;
          next_state   = pulse_timer_pkg::ST_IDLE;
        end else if (tick && !count[CNT_WIDTH-1]) begin
          next_count = count + 1'b1;
        end
      end
      default: begin
        next_state = pulse_timer_pkg::ST_IDLE;
      end
    endcase
    // msb reached: phase beyond the sensor's longest, line likely broken
    if (count[CNT_WIDTH-1]) begin
      next_err = 1'b1;
    end
  end

  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state    <= pulse_timer_pkg::ST_IDLE;
      count    <= CNT_WIDTH'(pulse_timer_pkg::CNT_RESET);
      high_lat <= CNT_WIDTH'(pulse_timer_pkg::CNT_RESET);
      low_lat  <= CNT_WIDTH'(pulse_timer_pkg::CNT_RESET);
      done_r   <= 1'b0;
      busy_r   <= 1'b0;
      err_r    <= 1'b0;
    end else begin
      state    <= next_state;
      count    <= next_count;
      high_lat <= next_high_lat;
      low_lat  <= next_low_lat;
      done_r   <= next_done;
      busy_r   <= next_busy;
      err_r    <= next_err;
    end
  end

  // outputs straight from flops
  assign high_phase_time_o = high_lat;
  assign low_phase_time_o  = low_lat;
  assign done_o            = done_r;
  assign busy_o            = busy_r;
  assign error_o           = err_r;

  // named steps of one measurement
  sequence s_high_fall;
    state == pulse_timer_pkg::ST_HIGH && fall;
  endsequence
  sequence s_low_rise;
    state == pulse_timer_pkg::ST_LOW && rise;
  endsequence

  // settled rise gives a rise pulse only
  a_edge_pulse_rise: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    $rose(sync_b) |-> rise && !fall)
    else $error("rise not flagged");
  // settled fall gives a fall pulse only
  a_edge_pulse_fall: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    $fell(sync_b) |-> fall && !rise)
    else $error("fall not flagged");
  // synchroniser delays the pin by two edges
  a_sync_two_stage: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    $past(sys_rst_i, 2) == 1'b0 |-> sync_b == $past(flag_input_line_i, 2))
    else $error("sync depth wrong");
  // no second tick within seven clocks of a tick
  a_tick_spacing: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    $rose(tick) |=> !tick [*7])
    else $error("ticks too close");
  // each tick coincides with the n-1 reload
  a_prescale_load: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    tick |-> prescale == pulse_timer_pkg::PRESCALE_LOAD)
    else $error("prescaler reload wrong");
  // fall during high captures count and clears it
  a_high_capture: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    s_high_fall |=>
      high_lat == $past(count) && count == '0 && state == pulse_timer_pkg::ST_LOW)
    else $error("high capture wrong");
  // rise during low ends measurement with done
  a_low_capture: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    s_low_rise |=>
      low_lat == $past(count) && done_r && state == pulse_timer_pkg::ST_IDLE)
    else $error("low capture wrong");
  // counter moves only on a tick, an edge or a start
  a_count_hold: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    (!tick && !edge_any && !start_i) |=> count == $past(count))
    else $error("count moved without tick");
  // line still high keeps the sequencer in wait-low
  a_align_wait: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    (state == pulse_timer_pkg::ST_WAIT_LOW && sync_b) |=>
      state == pulse_timer_pkg::ST_WAIT_LOW)
    else $error("left wait-low early");
  // msb seen raises the sticky error next cycle
  a_msb_error: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    count[CNT_WIDTH-1] |=> err_r)
    else $error("overflow not flagged");
  // latches stay put while idle without start
  a_latch_held: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    (state == pulse_timer_pkg::ST_IDLE) |=> $stable(high_lat) && $stable(low_lat))
    else $error("latches changed");
  // start clears counter to zero
  a_start_clear: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    (state == pulse_timer_pkg::ST_IDLE && start_i) |=> count == '0 && busy_r)
    else $error("start did not clear");
endmodule
`default_nettype wire

//--- logic/pulse_timer_pkg.sv
`default_nettype none
package pulse_timer_pkg;
  // counter geometry
  localparam int CNT_WIDTH   = 16;          // two cascaded byte stages
  localparam int STAGE_WIDTH = 8;           // width of one stage
  // reference tick rate and system clock
  localparam int CLK_HZ      = 125_000_000; // clock_i rate
  localparam int TICK_HZ     = 1_000_000;   // counting reference, 1 us resolution
  // prescaler: divide by n, load n-1
  localparam int PRESCALE_N  = CLK_HZ / TICK_HZ;
  localparam logic [7:0] PRESCALE_LOAD = 8'(PRESCALE_N - 1);
  // longest legal phase, in microseconds
  localparam int MAX_PHASE_US = 32_000;
  // reset values
  localparam logic [15:0] CNT_RESET   = 16'h0000;
  localparam logic [15:0] CNT_PRELOAD = 16'hFFFF; // down-count preload
  // capture sequencer states
  typedef enum logic [2:0] {
    ST_IDLE     = 3'b000, // armed, waiting
    ST_WAIT_LOW = 3'b001, // wait for line low
    ST_WAIT_HI  = 3'b010, // wait for rising edge
    ST_HIGH     = 3'b011, // timing high phase
    ST_LOW      = 3'b100  // timing low phase
  } meas_state_e;
endpackage
`default_nettype wire

//--- test/sensor_model.sv
`timescale 1ns/1ns
`default_nettype none
// behavioural sensor: one line, no clock or select
module sensor_model (
  output var logic line_o  // duty-cycle output line
);
  // idle level high between commanded phases
  initial begin
    line_o = 1'b1;
  end
  // hold one level for a span in microseconds; phases stay below 32 ms
  // unless a scenario commands a stuck line
  task automatic phase(input logic lvl, input int us);
    line_o = lvl;
    #(us * 1000 + 3);  // odd offset keeps edges off the clock grid
  endtask
endmodule
`default_nettype wire

//--- test/duty_cycle_pulse_timer_bench.sv
`timescale 1ns/1ns
`default_nettype none
module duty_cycle_pulse_timer_bench;
  localparam int W = 8;        // short counter: msb after 128 ticks
  logic         clock_i;       // system clock
  logic         sys_rst_i;     // async reset
  logic         start_i;       // start request
  logic         line;          // sensor line
  logic [W-1:0] high_t;        // latched high count
  logic [W-1:0] low_t;         // latched low count
  logic         done;          // pair latched
  logic         busy;          // running
  logic         err;           // overflow flag
  int           failures = 0;  // mismatches
  int           n_tests  = 0;  // comparisons

  sensor_model P (.line_o(line));
  duty_cycle_pulse_timer #(.CNT_WIDTH(W)) DUT (
    .clock_i(clock_i), .sys_rst_i(sys_rst_i), .flag_input_line_i(line),
    .start_i(start_i), .high_phase_time_o(high_t), .low_phase_time_o(low_t),
    .done_o(done), .busy_o(busy), .error_o(err));

  // 125 MHz clock
  initial begin
    clock_i = 1'b0;
    forever #4 clock_i = ~clock_i;
  end

  // compare with tolerance in ticks
  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input int tol);
    int d;
    n_tests++;
    d = int'(seen) - int'(exp);
    if ($isunknown(seen) || d > tol || d < -tol) begin
      failures++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // verdict and end of run
  task automatic results();
    $display("failures=%0d n_tests=%0d", failures, n_tests);
    if (failures == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // one-cycle start pulse, busy follows
  task automatic start_meas();
    @(posedge clock_i); #1 start_i = 1'b1;
    @(posedge clock_i); #1 start_i = 1'b0;
    check(16'(busy), 16'h0001, 0);
  endtask

  // wait for done under a bound
  task automatic wait_done(input int lim);
    int k;
    for (k = 0; k < lim; k++) begin
      @(posedge clock_i); #1;
      if (done === 1'b1) break;
    end
    check(16'(done), 16'h0001, 0);
  endtask

  // full period, line high at start, refused second start
  task automatic measure(input int h, input int l);
    fork
      begin
        P.phase(1'b1, 5);
        P.phase(1'b0, 10);
        P.phase(1'b1, h);
        P.phase(1'b0, l);
        P.phase(1'b1, 0);
      end
    join_none
    start_meas();
    repeat (20) @(posedge clock_i);
    #1 start_i = 1'b1;  // ignored while busy
    @(posedge clock_i); #1 start_i = 1'b0;
    wait_done((17 + h + l) * 125);
    check(16'(high_t), 16'(h), 1);
    check(16'(low_t), 16'(l), 1);
    @(posedge clock_i); #1;
    check(16'(done), 16'h0000, 0);
    check(16'(busy), 16'h0000, 0);
  endtask

  // stuck-high line flags overflow, sticky until next start
  task automatic overflow();
    fork
      begin
        P.phase(1'b0, 10);
        P.phase(1'b1, 200);
        P.phase(1'b0, 10);
        P.phase(1'b1, 0);
      end
    join_none
    start_meas();
    #150_000;
    check(16'(err), 16'h0001, 0);
    check(16'(busy), 16'h0001, 0);
    wait_done(90 * 125);
    check(16'(low_t), 16'd10, 1);
    check(16'(high_t), 16'(1 << (W - 1)), 0);
    check(16'(err), 16'h0001, 0);
    start_meas();
    check(16'(err), 16'h0000, 0);
  endtask

  // main sequence
  initial begin
    start_i   = 1'b0;
    sys_rst_i = 1'b1;
    repeat (5) @(posedge clock_i);
    #1 sys_rst_i = 1'b0;
    check(16'(done | busy | err), 16'h0000, 0);
    measure(40, 60);
    measure(90, 15);
    overflow();
    results();
  end

  // watchdog
  initial begin
    #700_000;
    failures++;
    results();
  end
endmodule
`default_nettype wire
